// [pkg/sgc_defines.vh]
`ifndef SGC_DEFINES_VH
`define SGC_DEFINES_VH

// clock and derived timing
`define SGC_CLK_PERIOD_NS 40
`define SGC_STB_DLY_NS 200
`define SGC_ACK_DLY_NS 400
`define SGC_STB_DLY_CYC ((`SGC_STB_DLY_NS + `SGC_CLK_PERIOD_NS - 1) / `SGC_CLK_PERIOD_NS)
`define SGC_ACK_DLY_CYC ((`SGC_ACK_DLY_NS + `SGC_CLK_PERIOD_NS - 1) / `SGC_CLK_PERIOD_NS)
`define SGC_TAP_FINE_NS 3
`define SGC_TAP_COARSE_NS 9
`define SGC_TAP_FINE_CYC ((`SGC_TAP_FINE_NS + `SGC_CLK_PERIOD_NS - 1) / `SGC_CLK_PERIOD_NS)
`define SGC_TAP_COARSE_CYC ((`SGC_TAP_COARSE_NS + `SGC_CLK_PERIOD_NS - 1) / `SGC_CLK_PERIOD_NS)

// op codes
`define SGC_OP_TURN_ON 8'h00
`define SGC_OP_TURN_OFF 8'hF0
`define SGC_OP_READ_NEXT 8'h80
`define SGC_OP_GATE_CLEAR 8'hE0
`define SGC_HI_SELECT 4'h1
`define SGC_HI_CONTROL 4'h2
`define SGC_HI_DOUBLE 4'h3
`define SGC_HI_CNT_LOW 4'h5
`define SGC_HI_CNT_MID 4'h6
`define SGC_HI_CNT_HIGH 4'h7

// bit positions in the select settings (op 1x, line = low nibble bits 3..1)
`define SGC_SEL_BEGIN_SRC 0
`define SGC_SEL_CLOCK_SRC 1
`define SGC_SEL_END_SRC 2
`define SGC_SEL_QUAL_SRC 3
`define SGC_SEL_BEGIN_EDGE 4
`define SGC_SEL_CLOCK_EDGE 5
`define SGC_SEL_END_EDGE 6
`define SGC_SEL_QUAL_POL 7

// bit positions in the control settings (op 2x)
`define SGC_CTL_DLY3 0
`define SGC_CTL_DLY6 1
`define SGC_CTL_DLY9 2
`define SGC_CTL_DLY18 3
`define SGC_CTL_ARM 4
`define SGC_CTL_SOC 5

// synchronised pin vector positions and reset value
`define SGC_PIN_STB 0
`define SGC_PIN_ACK 1
`define SGC_PIN_BEGIN 2
`define SGC_PIN_END 3
`define SGC_PIN_CLOCK 4
`define SGC_PIN_QUAL 5
`define SGC_PIN_SYNC 6
`define SGC_PIN_PROBE 7
`define SGC_PIN_RESET 8'h03

// apb map
`define SGC_ADDR_STATUS 8'h00
`define SGC_ADDR_SETTINGS 8'h04
`define SGC_ADDR_COUNT 8'h08
`define SGC_ADDR_CONTROL 8'h0C
`define SGC_CTRL_CLEAR 0

`endif

// [rtl/sgc_tap_line.v]
`timescale 1ns/1ps
`include "sgc_defines.vh"

// three equal delay elements with a 1-of-4 tap selector
module sgc_tap_line #(
  parameter ELEM_CYC = 1
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_data,
  input wire [1:0] i_tap_sel,
  output reg o_data
);

  localparam LEN = 3 * ELEM_CYC;

  reg [LEN-1:0] chain_reg;

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      chain_reg <= {LEN{1'b0}};
    end else begin
      chain_reg <= {chain_reg[LEN-2:0], i_data};
    end
  end

  always @* begin
    case (i_tap_sel)
      2'h0: o_data = i_data;
      2'h1: o_data = chain_reg[ELEM_CYC-1];
      2'h2: o_data = chain_reg[2*ELEM_CYC-1];
      default: o_data = chain_reg[LEN-1];
    endcase
  end

endmodule

// [rtl/sgc_control_gate.v]
`timescale 1ns/1ps
`include "sgc_defines.vh"

// What this block does
// - every falling host strobe latches the pod bus op code into the receive buffer
// - op 00h turns the module on and sets the sync flip-flop
// - host strobe reaches the pod only through a delay
// - while sync is clear the pod acknowledge returns to the host unchanged
// - while sync is set, the host gets a delayed strobe copy as acknowledge
// - with the module on, every latched op code is decoded except the one after op 80h
// - ops 1x and 2x latch a control line chosen by the low nibble
// - after op 80h the next strobe enables the transmit buffer at acknowledge time
// - op F0h raises interface-off and turns the decoder off
// - next strobe after interface-off clears sync unless it carries op 00h, restoring pod traffic
// - begin, end, clock from external pin or pod sync; qualifier pin or constant
// - begin, end, clock use chosen edge; qualifier is a level of chosen polarity
// - double-clock mode gives a pulse on both clock edges
// - armed begin edge sets start-received, shown as status
// - gate open while started, not stopped, count not at zero and qualifier active
// - first gated pulse at first clock after begin; clock path delayed to match
// - end edge sets stop, closing the gate; stop shown as status
// - after a stop a gate clear is needed before a new start
// - stop-on-count decrements on gated pulses and stops at zero
// - probe data passes two cascaded 1-of-4 tap selectors, fine and coarse
// - op 29h arms, op 28h disarms
// - ops 5x, 6x, 7x load the low, middle, high count nibble
// - op E0h issues the gate clear
module sgc_control_gate (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_host_strobe_n,
  input wire i_pod_acknowledge_n,
  input wire [7:0] i_pod_bus,
  output wire [7:0] o_pod_bus,
  output wire o_pod_bus_oe,
  output wire o_forwarded_host_strobe_n,
  output wire o_returned_acknowledge_n,
  output wire o_interface_off,
  output wire o_module_active,
  input wire i_external_begin_input,
  input wire i_external_end_input,
  input wire i_external_clock_input,
  input wire i_external_qualifier_input,
  input wire i_pod_sync,
  input wire i_probe_data,
  input wire [3:0] i_tx_nibble,
  output wire o_start_received,
  output wire o_stop_received,
  output wire o_gate_open,
  output wire o_gated_clock,
  output wire o_delayed_probe_data,
  output wire o_gate_clear,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr
);

  localparam STB_CYC = `SGC_STB_DLY_CYC;
  localparam ACK_CYC = `SGC_ACK_DLY_CYC;

  // pin synchronisers
  reg [7:0] pin_meta_reg;
  reg [7:0] pin_sync_reg;
  reg [7:0] pin_prev_reg;
  reg [7:0] bus_meta_reg;
  reg [7:0] bus_sync_reg;

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_meta_reg <= `SGC_PIN_RESET;
      pin_sync_reg <= `SGC_PIN_RESET;
      pin_prev_reg <= `SGC_PIN_RESET;
      bus_meta_reg <= 8'h00;
      bus_sync_reg <= 8'h00;
    end else begin
      pin_meta_reg <= {i_probe_data, i_pod_sync, i_external_qualifier_input,
                       i_external_clock_input, i_external_end_input,
                       i_external_begin_input, i_pod_acknowledge_n, i_host_strobe_n};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
      bus_meta_reg <= i_pod_bus;
      bus_sync_reg <= bus_meta_reg;
    end
  end
  wire [7:0] pin_rise = pin_sync_reg & ~pin_prev_reg;
  wire [7:0] pin_fall = ~pin_sync_reg & pin_prev_reg;
  wire stb_fall = pin_fall[`SGC_PIN_STB];
  // strobe delay line: forward tap and acknowledge tap
  reg [ACK_CYC-1:0] stb_line_reg;
  wire stb_dly = stb_line_reg[STB_CYC-1];
  wire ack_dly = stb_line_reg[ACK_CYC-1];

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stb_line_reg <= {ACK_CYC{1'b1}};
    end else begin
      stb_line_reg <= {stb_line_reg[ACK_CYC-2:0], pin_sync_reg[`SGC_PIN_STB]};
    end
  end
  // command state
  reg [7:0] rx_buf_reg;
  reg active_reg;
  reg sync_reg;
  reg interface_off_reg;
  reg rd_pend_reg;
  reg rd_wait_reg;
  reg tx_en_reg;
  reg [3:0] tx_data_reg;
  reg [7:0] sel_reg;
  reg [7:0] ctl_reg;
  reg dbl_reg;
  reg [11:0] preset_reg;
  reg preset_load_reg;
  reg op_clear_reg;
  reg fwd_stb_reg;
  reg ret_ack_reg;
  wire [3:0] op_hi = bus_sync_reg[7:4];
  wire [3:0] op_lo = bus_sync_reg[3:0];
  wire [2:0] op_line = bus_sync_reg[3:1];
  wire op_val = bus_sync_reg[0];

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_buf_reg <= 8'h00;
      active_reg <= 1'b0;
      sync_reg <= 1'b0;
      interface_off_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      sel_reg <= 8'h00;
      ctl_reg <= 8'h00;
      dbl_reg <= 1'b0;
      preset_reg <= 12'h000;
      preset_load_reg <= 1'b0;
      op_clear_reg <= 1'b0;
    end else begin
      preset_load_reg <= 1'b0;
      op_clear_reg <= 1'b0;
      if (stb_fall) begin
        rx_buf_reg <= bus_sync_reg;
        if (!active_reg) begin
          if (bus_sync_reg == `SGC_OP_TURN_ON) begin
            active_reg <= 1'b1;
            sync_reg <= 1'b1;
            interface_off_reg <= 1'b0;
          end else if (interface_off_reg) begin
            sync_reg <= 1'b0;
            interface_off_reg <= 1'b0;
          end
        end else if (rd_pend_reg) begin
          rd_pend_reg <= 1'b0;
        end else begin
          if (bus_sync_reg == `SGC_OP_TURN_OFF) begin
            active_reg <= 1'b0;
            interface_off_reg <= 1'b1;
          end else if (bus_sync_reg == `SGC_OP_READ_NEXT) begin
            rd_pend_reg <= 1'b1;
          end else if (bus_sync_reg == `SGC_OP_GATE_CLEAR) begin
            op_clear_reg <= 1'b1;
          end else begin
            case (op_hi)
              `SGC_HI_SELECT: sel_reg[op_line] <= op_val;
              `SGC_HI_CONTROL: ctl_reg[op_line] <= op_val;
              `SGC_HI_DOUBLE: dbl_reg <= op_val;
              `SGC_HI_CNT_LOW: begin
                preset_reg[3:0] <= op_lo;
                preset_load_reg <= 1'b1;
              end
              `SGC_HI_CNT_MID: begin
                preset_reg[7:4] <= op_lo;
                preset_load_reg <= 1'b1;
              end
              `SGC_HI_CNT_HIGH: begin
                preset_reg[11:8] <= op_lo;
                preset_load_reg <= 1'b1;
              end
              default: ;
            endcase
          end
        end
      end
    end
  end
  // read flip-flop and transmit buffer
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_wait_reg <= 1'b0;
      tx_en_reg <= 1'b0;
      tx_data_reg <= 4'h0;
    end else begin
      if (stb_fall && active_reg && rd_pend_reg) begin
        rd_wait_reg <= 1'b1;
      end else if (rd_wait_reg && !ack_dly) begin
        rd_wait_reg <= 1'b0;
        tx_en_reg <= 1'b1;
        tx_data_reg <= i_tx_nibble;
      end else if (tx_en_reg && ack_dly) begin
        tx_en_reg <= 1'b0;
      end
    end
  end
  // pod handshake path
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fwd_stb_reg <= 1'b1;
      ret_ack_reg <= 1'b1;
    end else begin
      fwd_stb_reg <= sync_reg ? 1'b1 : stb_dly;
      ret_ack_reg <= sync_reg ? ack_dly : pin_sync_reg[`SGC_PIN_ACK];
    end
  end

  // gate section: source and edge selection
  wire begin_rise = sel_reg[`SGC_SEL_BEGIN_SRC] ? pin_rise[`SGC_PIN_SYNC] : pin_rise[`SGC_PIN_BEGIN];
  wire begin_fall = sel_reg[`SGC_SEL_BEGIN_SRC] ? pin_fall[`SGC_PIN_SYNC] : pin_fall[`SGC_PIN_BEGIN];
  wire end_rise = sel_reg[`SGC_SEL_END_SRC] ? pin_rise[`SGC_PIN_SYNC] : pin_rise[`SGC_PIN_END];
  wire end_fall = sel_reg[`SGC_SEL_END_SRC] ? pin_fall[`SGC_PIN_SYNC] : pin_fall[`SGC_PIN_END];
  wire clk_rise = sel_reg[`SGC_SEL_CLOCK_SRC] ? pin_rise[`SGC_PIN_SYNC] : pin_rise[`SGC_PIN_CLOCK];
  wire clk_fall = sel_reg[`SGC_SEL_CLOCK_SRC] ? pin_fall[`SGC_PIN_SYNC] : pin_fall[`SGC_PIN_CLOCK];
  wire qual_lvl = sel_reg[`SGC_SEL_QUAL_SRC] ? 1'b1 : pin_sync_reg[`SGC_PIN_QUAL];
  wire qual_ok = sel_reg[`SGC_SEL_QUAL_SRC] | (qual_lvl ^ sel_reg[`SGC_SEL_QUAL_POL]);
  wire begin_edge = sel_reg[`SGC_SEL_BEGIN_EDGE] ? begin_fall : begin_rise;
  wire end_edge = sel_reg[`SGC_SEL_END_EDGE] ? end_fall : end_rise;
  wire clk_edge = dbl_reg ? (clk_rise | clk_fall) :
                  (sel_reg[`SGC_SEL_CLOCK_EDGE] ? clk_fall : clk_rise);

  reg start_reg;
  reg stop_reg;
  reg clk_pulse_reg;
  reg [11:0] count_reg;
  reg apb_clear_reg;
  wire gate_clear = op_clear_reg | apb_clear_reg;
  wire soc_en = ctl_reg[`SGC_CTL_SOC];
  wire count_zero = soc_en && (count_reg == 12'h000);
  wire gate_open = start_reg & ~stop_reg & qual_ok & ~count_zero;
  wire gated_clock = clk_pulse_reg & gate_open;
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
      clk_pulse_reg <= 1'b0;
      count_reg <= 12'h000;
    end else begin
      clk_pulse_reg <= clk_edge;
      if (gate_clear) begin
        start_reg <= 1'b0;
        stop_reg <= 1'b0;
        count_reg <= preset_reg;
      end else if (preset_load_reg) begin
        count_reg <= preset_reg;
      end else if (soc_en && gated_clock) begin
        count_reg <= count_reg - 12'h001;
      end
      // in the clear cycle a begin edge sets start only if stop was clear, an end edge sets stop only if start was set
      if (begin_edge && ctl_reg[`SGC_CTL_ARM] && !stop_reg) begin
        start_reg <= 1'b1;
      end
      if ((end_edge || count_zero) && start_reg) begin
        stop_reg <= 1'b1;
      end
    end
  end

  // delay section: fine then coarse tap selectors
  wire fine_out;
  wire coarse_out;
  reg dly_data_reg;

  sgc_tap_line #(.ELEM_CYC(`SGC_TAP_FINE_CYC)) u_fine (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_data(pin_sync_reg[`SGC_PIN_PROBE]),
    .i_tap_sel({ctl_reg[`SGC_CTL_DLY6], ctl_reg[`SGC_CTL_DLY3]}),
    .o_data(fine_out)
  );
  sgc_tap_line #(.ELEM_CYC(`SGC_TAP_COARSE_CYC)) u_coarse (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_data(fine_out),
    .i_tap_sel({ctl_reg[`SGC_CTL_DLY18], ctl_reg[`SGC_CTL_DLY9]}),
    .o_data(coarse_out)
  );
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dly_data_reg <= 1'b0;
    end else begin
      dly_data_reg <= coarse_out;
    end
  end

  // apb slave, one wait-free access phase after setup
  reg pready_reg;
  reg pslverr_reg;
  reg [31:0] prdata_reg;
  reg [31:0] rd_mux;
  reg rd_hit;

  wire [31:0] status_word = {20'h00000, rx_buf_reg[3:0], tx_en_reg, rd_pend_reg,
                             gate_open, stop_reg, start_reg, interface_off_reg,
                             sync_reg, active_reg};
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (i_paddr)
      `SGC_ADDR_STATUS: rd_mux = status_word;
      `SGC_ADDR_SETTINGS: rd_mux = {15'h0000, dbl_reg, ctl_reg, sel_reg};
      `SGC_ADDR_COUNT: rd_mux = {4'h0, count_reg, 4'h0, preset_reg};
      `SGC_ADDR_CONTROL: rd_mux = 32'h00000000;
      default: rd_hit = 1'b0;
    endcase
  end

  wire apb_setup = i_psel & ~i_penable;
  wire apb_done = i_psel & i_penable & pready_reg;

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      apb_clear_reg <= 1'b0;
    end else begin
      apb_clear_reg <= 1'b0;
      if (apb_setup) begin
        pready_reg <= 1'b1;
        pslverr_reg <= ~rd_hit;
        prdata_reg <= i_pwrite ? 32'h00000000 : rd_mux;
      end else if (apb_done) begin
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
        if (i_pwrite && (i_paddr == `SGC_ADDR_CONTROL)) begin
          apb_clear_reg <= i_pwdata[`SGC_CTRL_CLEAR];
        end
      end
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_pod_bus = {2'h0, stop_reg, start_reg, tx_data_reg};
  assign o_pod_bus_oe = tx_en_reg;
  assign o_forwarded_host_strobe_n = fwd_stb_reg;
  assign o_returned_acknowledge_n = ret_ack_reg;
  assign o_interface_off = interface_off_reg;
  assign o_module_active = active_reg;
  assign o_start_received = start_reg;
  assign o_stop_received = stop_reg;
  assign o_gate_open = gate_open;
  assign o_gated_clock = gated_clock;
  assign o_delayed_probe_data = dly_data_reg;
  assign o_gate_clear = gate_clear;

endmodule

// [sim/sgc_control_gate_monitor.sv]
`timescale 1ns/1ps
module sgc_control_gate_monitor (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pod_acknowledge_n,
  input wire o_returned_acknowledge_n,
  input wire o_forwarded_host_strobe_n,
  input wire o_module_active,
  input wire o_interface_off,
  input wire o_pod_bus_oe,
  input wire o_start_received,
  input wire o_stop_received,
  input wire o_gate_open,
  input wire o_gated_clock,
  input wire o_gate_clear,
  input wire o_pready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  chk_apb_ready: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
    else $error("apb answer not in the single access cycle");
  chk_pod_blocked: assert property (o_module_active |-> o_forwarded_host_strobe_n)
    else $error("strobe reached the pod while active");
  chk_ack_pass: assert property ((!o_module_active && !o_interface_off
    && $stable(i_pod_acknowledge_n))[*5] |-> o_returned_acknowledge_n == i_pod_acknowledge_n)
    else $error("pod acknowledge not returned unchanged");
  chk_tx_enable: assert property ($rose(o_pod_bus_oe) |->
    o_module_active ##[0:2] !o_returned_acknowledge_n)
    else $error("transmit enable outside an acknowledge");
  chk_interface_off: assert property ($rose(o_interface_off) |-> !o_module_active)
    else $error("interface off while decoder enabled");
  chk_gate_open: assert property (o_gate_open |-> o_start_received && !o_stop_received)
    else $error("gate open without start or after stop");
  chk_gated_clk: assert property (o_gated_clock |-> o_gate_open)
    else $error("gated pulse with gate closed");
  chk_stop_order: assert property ($rose(o_stop_received) |-> $past(o_start_received))
    else $error("stop set before start");
  chk_clear_flags: assert property (o_gate_clear |=>
    (!o_start_received || !$past(o_stop_received)) &&
    (!o_stop_received || $past(o_start_received)))
    else $error("gate clear left a flag set");
  chk_flags_held: assert property ((o_start_received || o_stop_received) && !o_gate_clear
    |=> o_start_received == $past(o_start_received) || $rose(o_stop_received))
    else $error("gate flag changed without clear");
endmodule

bind sgc_control_gate sgc_control_gate_monitor sgc_control_gate_monitor_i (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pod_acknowledge_n(i_pod_acknowledge_n),
  .o_returned_acknowledge_n(o_returned_acknowledge_n),
  .o_forwarded_host_strobe_n(o_forwarded_host_strobe_n),
  .o_module_active(o_module_active), .o_interface_off(o_interface_off),
  .o_pod_bus_oe(o_pod_bus_oe), .o_start_received(o_start_received),
  .o_stop_received(o_stop_received), .o_gate_open(o_gate_open),
  .o_gated_clock(o_gated_clock), .o_gate_clear(o_gate_clear), .o_pready(o_pready)
);

// [sim/sgc_pod_model.sv]
`timescale 1ns/1ps
module sgc_pod_model (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_strobe_n,
  input wire i_slow,
  output logic o_ack_n,
  output int o_seen
);
  logic [7:0] dly_reg;
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dly_reg <= 8'hFF;
      o_seen <= 0;
    end else begin
      dly_reg <= {dly_reg[6:0], i_strobe_n};
      if (dly_reg[0] && !i_strobe_n) o_seen <= o_seen + 1;
    end
  end
  // the pod answers each strobe it sees after a short or a long delay
  assign o_ack_n = i_slow ? dly_reg[7] : dly_reg[1];
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic i_clk = 1'b0;
  logic rst_n = 1'b0;
  logic stb_n = 1'b1;
  logic [7:0] bus = 8'h00;
  logic [4:0] gin = 5'h00; // pod sync, qualifier, clock, end, begin
  logic probe = 1'b0, slow = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
  logic [7:0] paddr = 8'h00, cap;
  logic [31:0] pwd = 32'h0, rd;
  wire [7:0] pbo;
  wire [31:0] prd;
  wire oe, fwd_n, ret_n, ack_n, ioff, act, st, sp, go, gclk, dpr, gcl, rdy, serr;
  int fails = 0, checked = 0, gcnt = 0, afall = 0, oer = 0, seen;
  always #20 i_clk = ~i_clk;
  sgc_control_gate sgc_control_gate_i (.i_clk(i_clk), .i_reset_n(rst_n),
    .i_host_strobe_n(stb_n), .i_pod_acknowledge_n(ack_n), .i_pod_bus(bus), .o_pod_bus(pbo),
    .o_pod_bus_oe(oe), .o_forwarded_host_strobe_n(fwd_n), .o_returned_acknowledge_n(ret_n),
    .o_interface_off(ioff), .o_module_active(act), .i_external_begin_input(gin[0]),
    .i_external_end_input(gin[1]), .i_external_clock_input(gin[2]),
    .i_external_qualifier_input(gin[3]), .i_pod_sync(gin[4]), .i_probe_data(probe),
    .i_tx_nibble(4'hA), .o_start_received(st), .o_stop_received(sp), .o_gate_open(go),
    .o_gated_clock(gclk), .o_delayed_probe_data(dpr), .o_gate_clear(gcl), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd),
    .o_pready(rdy), .o_pslverr(serr));
  sgc_pod_model sgc_pod_model_i (.i_clk(i_clk), .i_reset_n(rst_n), .i_strobe_n(fwd_n),
    .i_slow(slow), .o_ack_n(ack_n), .o_seen(seen));
  always @(posedge i_clk) begin
    if (gclk === 1'b1) gcnt <= gcnt + 1;
    if ($fell(ret_n)) afall <= afall + 1;
    if ($rose(oe)) begin
      cap <= pbo;
      oer <= oer + 1;
    end
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    @(posedge i_clk);
    while (rdy !== 1'b1) @(posedge i_clk);
    rd = prd;
    err = serr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic op(input logic [7:0] c);
    @(posedge i_clk);
    bus <= c;
    repeat (4) @(posedge i_clk);
    stb_n <= 1'b0;
    repeat (16) @(posedge i_clk);
    stb_n <= 1'b1;
    repeat (16) @(posedge i_clk);
  endtask
  task automatic pin(input int b, input logic v);
    @(posedge i_clk);
    gin[b] <= v;
    repeat (5) @(posedge i_clk);
  endtask
  task automatic lat(output int n);
    @(posedge i_clk);
    probe <= 1'b1;
    n = 0;
    @(negedge i_clk);
    while (dpr !== 1'b1) begin
      @(negedge i_clk);
      n++;
    end
    @(posedge i_clk);
    probe <= 1'b0;
    repeat (12) @(posedge i_clk);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    int l1, l0, g0, i;
    repeat (4) @(posedge i_clk);
    rst_n <= 1'b1;
    op(8'h45);
    cmp("pod strobes", 1, seen);
    cmp("host acks", 1, afall);
    $display("test passthrough done");
    op(8'h00);
    apb(1'b0, 8'h00, 32'h0);
    cmp("active and sync", 3, rd[1:0]);
    cmp("pod strobes", 1, seen);
    cmp("host acks", 2, afall);
    $display("test turn_on done");
    for (i = 0; i < 8; i++) op({4'h1, i[2:0], 1'b1});
    apb(1'b0, 8'h04, 32'h0);
    cmp("select lines", 32'hFF, rd[7:0]);
    for (i = 0; i < 8; i++) begin
      op({4'h1, i[2:0], 1'b0});
      op({4'h2, i[2:0], 1'b1});
    end
    op(8'h2A);
    op(8'h31);
    apb(1'b0, 8'h04, 32'h0);
    cmp("settings", 32'h1DF00, rd[16:0]);
    $display("test settings done");
    lat(l1);
    for (i = 0; i < 4; i++) op({4'h2, i[2:0], 1'b0});
    lat(l0);
    cmp("probe delay", 6, l1 - l0);
    $display("test delay done");
    pin(3, 1'b1);
    op(8'hE0);
    g0 = gcnt;
    pin(0, 1'b1);
    cmp("start", 1, st);
    cmp("gate open", 1, go);
    repeat (2) begin
      pin(2, 1'b1);
      pin(2, 1'b0);
    end
    cmp("double pulses", 4, gcnt - g0);
    pin(1, 1'b1);
    cmp("stop", 1, sp);
    pin(2, 1'b1);
    pin(2, 1'b0);
    cmp("pulses after stop", 4, gcnt - g0);
    pin(0, 1'b0);
    pin(0, 1'b1);
    cmp("start while stopped", 1, st & sp);
    apb(1'b1, 8'h0C, 32'h1);
    repeat (3) @(posedge i_clk);
    cmp("flags cleared", 0, {st, sp});
    pin(0, 1'b0);
    pin(0, 1'b1);
    cmp("new window", 1, go);
    pin(3, 1'b0);
    cmp("qualifier off", 0, go);
    op(8'h28);
    op(8'hE0);
    pin(0, 1'b0);
    pin(0, 1'b1);
    cmp("disarmed start", 0, st);
    $display("test gate done");
    pin(3, 1'b1);
    pin(0, 1'b0);
    pin(1, 1'b0);
    op(8'h29);
    op(8'h2B);
    op(8'h53);
    op(8'h60);
    op(8'h71);
    op(8'hE0);
    apb(1'b0, 8'h08, 32'h0);
    cmp("preset", 32'h103, rd[11:0]);
    op(8'h70);
    g0 = gcnt;
    pin(0, 1'b1);
    repeat (3) begin
      pin(2, 1'b1);
      pin(2, 1'b0);
    end
    cmp("counted pulses", 3, gcnt - g0);
    cmp("count stop", 1, sp);
    $display("test count done");
    op(8'h2A);
    op(8'h11);
    op(8'h19);
    op(8'h17);
    op(8'h15);
    pin(3, 1'b0);
    op(8'hE0);
    pin(4, 1'b1);
    cmp("sync rise ignored", 0, st);
    pin(4, 1'b0);
    cmp("sync start", 1, go);
    op(8'h16);
    cmp("qualifier low", 0, go);
    op(8'h1F);
    cmp("low active", 1, go);
    op(8'h30);
    op(8'h1B);
    g0 = gcnt;
    pin(2, 1'b1);
    cmp("rising ignored", 0, gcnt - g0);
    pin(2, 1'b0);
    cmp("single pulse", 1, gcnt - g0);
    pin(4, 1'b1);
    cmp("sync stop", 1, sp);
    $display("test sources done");
    op(8'h80);
    op(8'h90);
    cmp("tx enables", 1, oer);
    cmp("tx nibble", 4'hA, cap[3:0]);
    cmp("pod status", 2'b11, cap[5:4]);
    $display("test read done");
    op(8'hF0);
    apb(1'b0, 8'h00, 32'h0);
    cmp("off state", 3'b110, rd[2:0]);
    slow <= 1'b1;
    g0 = afall;
    op(8'h46);
    repeat (12) @(posedge i_clk);
    apb(1'b0, 8'h00, 32'h0);
    cmp("restored", 0, rd[2:0]);
    cmp("last op nibble", 4'h6, rd[11:8]);
    cmp("pod strobes", 2, seen);
    cmp("host acks", 1, afall - g0);
    apb(1'b0, 8'h10, 32'h0);
    cmp("unmapped error", 1, err);
    $display("test turn_off done");
    tally_and_finish();
  end
endmodule
